//--- hdl/cps_pkg.sv
// Purpose: shared constants and carrier types for the clock prescaler block
// Assumes: 8-bit special-function register space, one oscillator clock
// Notes: register offsets are byte addresses in that space
package cps_pkg;

   // Register offsets
   localparam logic [7:0] PRESCALER_RELOAD_ADDR        = 8'h97;
   localparam logic [7:0] CORE_CLOCK_SPEED_CONTROL_ADDR = 8'h8f;
   localparam logic [7:0] SPI_CLOCK_SPEED_CONTROL_ADDR  = 8'haf;
   localparam logic [7:0] POWER_CONTROL_ADDR           = 8'h87;

   // Reset values
   localparam logic [7:0] PRESCALER_RELOAD_RESET = 8'hff;
   localparam logic [5:0] SPEED_SEL_RESET        = 6'h00;
   localparam logic       SPI_SPEED_SEL_RESET    = 1'h0;
   localparam logic [3:0] POWER_CONTROL_RESET    = 4'h0;

   // Fastest reload code, bypasses the prescaler
   localparam logic [7:0] RELOAD_FASTEST = 8'hff;

   // Field positions, core clock speed control
   localparam int DOUBLE_SPEED_BIT      = 0;
   localparam int TIMER0_SPEED_SEL_BIT  = 1;
   localparam int WATCHDOG_SPEED_SEL_BIT = 6;
   // Field positions, spi clock speed control
   localparam int SPI_SPEED_SEL_BIT     = 0;
   // Field positions, power control
   localparam int IDLE_REQUEST_BIT      = 0;
   localparam int POWER_DOWN_REQUEST_BIT = 1;
   localparam int USER_FLAG_A_BIT       = 2;
   localparam int USER_FLAG_B_BIT       = 3;

   // Timing counts
   localparam logic [2:0] MACHINE_CYCLE_LAST = 3'h5;   // six core clocks per machine cycle
   localparam int         PERIPH_COUNT       = 7;      // timer0..2, uart, counter array, watchdog, spi

   // Register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } cps_bus_type;

   // Clock enables handed to the core and the peripherals
   typedef struct packed {
      logic                    cpuTick;
      logic                    machineCycleTick;
      logic [PERIPH_COUNT-1:0] periphTick;
   } cps_ticks_type;

endpackage : cps_pkg

//--- hdl/cps_divider.sv
// Purpose: programmable prescaler dividing a base tick by twice (255 - reload code), all ones passing every tick
// Assumes: tickIn is a one-cycle enable on the same clock
// Notes: a new reload code takes effect at the next period boundary; all ones takes effect at once
module cps_divider (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       tickIn,
   input  wire logic [7:0] reload,
   output logic            tickOut
);

   typedef struct packed {
      logic [8:0] cnt;
      logic       tick;
   } cps_div_state_type;

   cps_div_state_type st_q;
   cps_div_state_type st_d;
   logic [8:0]        loadVal;

   // Period is twice (255 - reload) base ticks; count loads period minus one
   assign loadVal = {cps_pkg::RELOAD_FASTEST - reload, 1'b0} - 9'h001;

   // Count down on each base tick, reloading at zero
   always_comb begin
      st_d      = st_q;
      st_d.tick = 1'b0;
      if (tickIn) begin
         if (reload == cps_pkg::RELOAD_FASTEST) begin
            st_d.tick = 1'b1;   // R4
            st_d.cnt  = 9'h000;
         end else if (st_q.cnt == 9'h000) begin
            st_d.tick = 1'b1;   // R5 R6
            st_d.cnt  = loadVal;   // R2 R3
         end else begin
            st_d.cnt = st_q.cnt - 9'h001;
         end
      end
   end

   // State register, frozen while the clock enable is low
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '0;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign tickOut = st_q.tick;

   property p_r3;
      @(posedge clk) disable iff (rst)
      (ce && tickIn && st_q.cnt == 9'h000 && reload == 8'h00) |=> (st_q.cnt == 9'h1fd && st_q.tick);
   endproperty
   a_r3: assert property (p_r3) else $error("slowest reload did not load 509"); // R3

   property p_r4;
      @(posedge clk) disable iff (rst)
      (ce && tickIn && reload == 8'hff) |=> st_q.tick;
   endproperty
   a_r4: assert property (p_r4) else $error("fastest reload did not pass every tick"); // R4

endmodule : cps_divider

//--- hdl/cps_clock_prescaler.sv
// Purpose: oscillator prescaler, double-speed select and power-mode clock gating
// Assumes: clk is the oscillator; strap and wake inputs come from same-clock logic
// Notes: produces clock enables, not gated clocks, for core and peripherals
// Behaviour
// R1 - Reset loads reload with all ones: core and peripheral clocks at oscillator/2.
// R2 - Any reload code 00h to FFh divides the selected oscillator for both clocks.
// R3 - Reload zero gives oscillator/1020 standard, oscillator/510 double speed.
// R4 - Reload all ones gives oscillator/2 standard, undivided in double speed.
// R5 - Double speed, reload not all ones: divide by 2 x (255 - reload).
// R6 - Standard mode, reload not all ones: divide by 4 x (255 - reload).
// R7 - Standard mode inserts a halving stage; double speed bypasses it.
// R8 - Machine cycle is 12 oscillator periods standard, 6 in double speed.
// R9 - Double-speed bit changes take effect only on halved-clock rising edge.
// R10 - Reset loads the double-speed bit from the security byte; standard default.
// R11 - Double speed gives 6 periods and enables per-peripheral speed bits.
// R12 - Per-peripheral speed bits act only while double speed is active.
// R13 - Speed bit clear gives 6 periods, set gives 12, per peripheral.
// R14 - Power-down request stops all clocks; cleared by reset.
// R15 - Idle request freezes core clock only; cleared by interrupt or reset.
// R16 - Two user flags in power control, software only, no hardware effect.
// R17 - Reload register at 97h, 8 bits, resets to all ones.
// R18 - Core and peripheral clocks stay aligned and equal apart from halving.
//
// The plain strobed port was left to the implementer.
module cps_clock_prescaler (
   input  wire logic                           clk,
   input  wire logic                           rst,
   input  wire logic                           ce,
   input  wire logic [7:0]                     addr,
   input  wire logic [7:0]                     wdata,
   input  wire logic                           wr,
   input  wire logic                           rd,
   output logic      [7:0]                     rdata,
   input  wire logic                           securityDoubleSpeed,
   input  wire logic                           interruptWake,
   output logic                                cpuClkTick,
   output logic                                machineCycleTick,
   output logic      [cps_pkg::PERIPH_COUNT-1:0] periphClkTick,
   output logic                                doubleSpeedActive,
   output logic                                idleActive,
   output logic                                powerDownActive
);

   typedef struct packed {
      logic [7:0]            prescalerReload;
      logic [5:0]            speedSel;       // timer0..watchdog selects
      logic                  doubleSpeedReq; // software view
      logic                  spiSpeedSel;
      logic                  userFlagB;
      logic                  userFlagA;
      logic                  powerDownRequest;
      logic                  idleRequest;
      logic                  doubleSpeedAct; // value in force
      logic                  oscHalf;
      logic                  loadStrap;
      logic [2:0]            mcPhase;
      logic                  halfPhase;
      cps_pkg::cps_ticks_type ticks;
      logic [7:0]            rdata;
   } cps_state_type;

   cps_state_type                    st_q;
   cps_state_type                    st_d;
   cps_pkg::cps_bus_type             bus;
   logic                             baseTick;
   logic                             divTick;
   logic                             periphBase;
   logic [cps_pkg::PERIPH_COUNT-1:0] periphSel;
   logic [cps_pkg::PERIPH_COUNT-1:0] periphTickD;

   // Bus bundle, same-clock master so no synchroniser
   assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   // Halving stage ticks every second oscillator cycle; double speed bypasses it
   assign baseTick = (st_q.doubleSpeedAct | st_q.oscHalf) & ~st_q.powerDownRequest;   // R7 R14

   // Prescaler divides the base tick for core and peripherals alike
   cps_divider u_divider (
      .clk     (clk),
      .rst     (rst),
      .ce      (ce),
      .tickIn  (baseTick),
      .reload  (st_q.prescalerReload),
      .tickOut (divTick)
   );

   // One shared source keeps core and peripheral enables phase-aligned
   assign periphBase = divTick & ~st_q.powerDownRequest;   // R18 R14

   // Peripheral select vector, spi on top
   assign periphSel = {st_q.spiSpeedSel, st_q.speedSel};

   // Selected peripherals take every second tick, only in double speed
   generate
      for (genvar i = 0; i < cps_pkg::PERIPH_COUNT; i++) begin : g_periph
         assign periphTickD[i] = periphBase & (~(st_q.doubleSpeedAct & periphSel[i]) | st_q.halfPhase);   // R12 R13
      end
   endgenerate

   // Next-state logic: register writes, mode switching, clock enables, read data
   always_comb begin
      st_d       = st_q;
      st_d.rdata = 8'h00;

      // Halving stage runs freely so mode switching has a fixed reference
      st_d.oscHalf = ~st_q.oscHalf;   // R7

      // Strap captured one cycle after reset release
      st_d.loadStrap = 1'b0;
      if (st_q.loadStrap) begin
         st_d.doubleSpeedReq = securityDoubleSpeed;   // R10
      end

      // Register writes; reserved bits are dropped
      if (bus.wr) begin
         if (bus.addr == cps_pkg::PRESCALER_RELOAD_ADDR) begin
            st_d.prescalerReload = bus.wdata;   // R2 R17
         end else if (bus.addr == cps_pkg::CORE_CLOCK_SPEED_CONTROL_ADDR) begin
            st_d.doubleSpeedReq = bus.wdata[cps_pkg::DOUBLE_SPEED_BIT];   // R11
            st_d.speedSel = bus.wdata[cps_pkg::WATCHDOG_SPEED_SEL_BIT:cps_pkg::TIMER0_SPEED_SEL_BIT];   // R13
         end else if (bus.addr == cps_pkg::SPI_CLOCK_SPEED_CONTROL_ADDR) begin
            st_d.spiSpeedSel = bus.wdata[cps_pkg::SPI_SPEED_SEL_BIT];   // R13
         end else if (bus.addr == cps_pkg::POWER_CONTROL_ADDR) begin
            st_d.userFlagB        = bus.wdata[cps_pkg::USER_FLAG_B_BIT];   // R16
            st_d.userFlagA        = bus.wdata[cps_pkg::USER_FLAG_A_BIT];   // R16
            st_d.powerDownRequest = bus.wdata[cps_pkg::POWER_DOWN_REQUEST_BIT];   // R14
            st_d.idleRequest      = bus.wdata[cps_pkg::IDLE_REQUEST_BIT];   // R15
         end
      end

      // Interrupt wins over a same-cycle idle write so no wake is lost
      if (interruptWake) begin
         st_d.idleRequest = 1'b0;   // R15
      end

      // Mode switch only as the halved clock rises, avoiding a short pulse
      if (!st_q.oscHalf) begin
         st_d.doubleSpeedAct = st_q.doubleSpeedReq;   // R9
      end

      // Peripheral halving phase follows the shared tick
      if (divTick) begin
         st_d.halfPhase = ~st_q.halfPhase;
      end

      // Core enable frozen in idle and power-down
      st_d.ticks.cpuTick          = divTick & ~st_q.idleRequest & ~st_q.powerDownRequest;   // R15 R14
      st_d.ticks.machineCycleTick = 1'b0;
      if (st_d.ticks.cpuTick) begin
         if (st_q.mcPhase == cps_pkg::MACHINE_CYCLE_LAST) begin
            st_d.mcPhase                = 3'h0;
            st_d.ticks.machineCycleTick = 1'b1;   // R8 R11
         end else begin
            st_d.mcPhase = st_q.mcPhase + 3'h1;
         end
      end
      st_d.ticks.periphTick = periphTickD;   // R12

      // Read data stand only in the cycle after the strobe
      if (bus.rd) begin
         if (bus.addr == cps_pkg::PRESCALER_RELOAD_ADDR) begin
            st_d.rdata = st_q.prescalerReload;
         end else if (bus.addr == cps_pkg::CORE_CLOCK_SPEED_CONTROL_ADDR) begin
            st_d.rdata = {1'b0, st_q.speedSel, st_q.doubleSpeedReq};
         end else if (bus.addr == cps_pkg::SPI_CLOCK_SPEED_CONTROL_ADDR) begin
            st_d.rdata = {7'h00, st_q.spiSpeedSel};
         end else if (bus.addr == cps_pkg::POWER_CONTROL_ADDR) begin
            st_d.rdata = {4'h0, st_q.userFlagB, st_q.userFlagA, st_q.powerDownRequest, st_q.idleRequest};
         end
      end
   end

   // State register; reset constants, clock enable freezes everything
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q                  <= '0;
         st_q.prescalerReload  <= cps_pkg::PRESCALER_RELOAD_RESET;   // R1 R17
         st_q.speedSel         <= cps_pkg::SPEED_SEL_RESET;
         st_q.spiSpeedSel      <= cps_pkg::SPI_SPEED_SEL_RESET;
         {st_q.userFlagB, st_q.userFlagA, st_q.powerDownRequest, st_q.idleRequest}
                               <= cps_pkg::POWER_CONTROL_RESET;   // R14 R15
         st_q.loadStrap        <= 1'b1;   // R10
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   // Outputs straight from the state register
   assign rdata             = st_q.rdata;
   assign cpuClkTick        = st_q.ticks.cpuTick;
   assign machineCycleTick  = st_q.ticks.machineCycleTick;
   assign periphClkTick     = st_q.ticks.periphTick;
   assign doubleSpeedActive = st_q.doubleSpeedAct;
   assign idleActive        = st_q.idleRequest;
   assign powerDownActive   = st_q.powerDownRequest;

   // Reset leaves the fastest standard setting
   property p_r1;
      @(posedge clk) rst |=> (st_q.prescalerReload == 8'hff && !st_q.doubleSpeedAct);
   endproperty
   a_r1: assert property (p_r1) else $error("reset did not restore reload all ones"); // R1

   property p_r9;
      @(posedge clk) disable iff (rst)
      (st_q.doubleSpeedAct != $past(st_q.doubleSpeedAct)) |-> (st_q.oscHalf && !$past(st_q.oscHalf));
   endproperty
   a_r9: assert property (p_r9) else $error("mode changed off the halved clock edge"); // R9

   property p_r10;
      @(posedge clk) disable iff (rst)
      (!rst && ce && st_q.loadStrap) |=> (st_q.doubleSpeedReq == $past(securityDoubleSpeed));
   endproperty
   a_r10: assert property (p_r10) else $error("strap not loaded after reset"); // R10

   property p_r12;
      @(posedge clk) disable iff (rst)
      (ce && !st_q.doubleSpeedAct) |=> (st_q.ticks.periphTick == {cps_pkg::PERIPH_COUNT{$past(periphBase)}});
   endproperty
   a_r12: assert property (p_r12) else $error("peripheral halved outside double speed"); // R12

   property p_r14;
      @(posedge clk) disable iff (rst)
      (ce && st_q.powerDownRequest) |=> (st_q.ticks == '0);
   endproperty
   a_r14: assert property (p_r14) else $error("clock ran during power-down"); // R14

   property p_r15;
      @(posedge clk) disable iff (rst)
      (ce && interruptWake) |=> !st_q.idleRequest;
   endproperty
   a_r15: assert property (p_r15) else $error("interrupt did not end idle"); // R15

   property p_r15_core;
      @(posedge clk) disable iff (rst)
      (ce && st_q.idleRequest && !st_q.powerDownRequest && divTick) |=> (!st_q.ticks.cpuTick && st_q.ticks.periphTick[0] == $past(periphTickD[0]));
   endproperty
   a_r15_core: assert property (p_r15_core) else $error("idle did not freeze core only"); // R15

   property p_r8;
      @(posedge clk) disable iff (rst)
      st_q.ticks.machineCycleTick |-> (st_q.ticks.cpuTick && st_q.mcPhase == 3'h0);
   endproperty
   a_r8: assert property (p_r8) else $error("machine cycle not six core clocks"); // R8

   // Standard mode, no idle: peripheral enables coincide with the core enable
   property p_r18;
      @(posedge clk) disable iff (rst)
      (!rst && ce && !st_q.idleRequest && !st_q.doubleSpeedAct)
         |=> (st_q.ticks.periphTick == {cps_pkg::PERIPH_COUNT{st_q.ticks.cpuTick}});
   endproperty
   a_r18: assert property (p_r18) else $error("core and peripheral enables apart"); // R18

   property p_r2_write;
      @(posedge clk) disable iff (rst)
      (!rst && ce && wr && addr == cps_pkg::PRESCALER_RELOAD_ADDR) |=> (st_q.prescalerReload == $past(wdata));
   endproperty
   a_r2_write: assert property (p_r2_write) else $error("reload write not taken"); // R2

   property p_r17_hold;
      @(posedge clk) disable iff (rst)
      (!rst && !(ce && wr && addr == cps_pkg::PRESCALER_RELOAD_ADDR)) |=> $stable(st_q.prescalerReload);
   endproperty
   a_r17_hold: assert property (p_r17_hold) else $error("reload changed unasked"); // R17

   property p_r17_read;
      @(posedge clk) disable iff (rst)
      (!rst && ce && rd && addr == cps_pkg::PRESCALER_RELOAD_ADDR)
         |=> (st_q.rdata == $past(st_q.prescalerReload));
   endproperty
   a_r17_read: assert property (p_r17_read) else $error("reload read wrong"); // R17

   property p_r17_rdata;
      @(posedge clk) disable iff (rst)
      (!rst && ce && !rd) |=> (st_q.rdata == 8'h00);
   endproperty
   a_r17_rdata: assert property (p_r17_rdata) else $error("read data stood too long"); // R17

   property p_r16_flags;
      @(posedge clk) disable iff (rst)
      (!rst && ce && wr && addr == cps_pkg::POWER_CONTROL_ADDR)
         |=> ({st_q.userFlagB, st_q.userFlagA} == $past(wdata[cps_pkg::USER_FLAG_B_BIT:cps_pkg::USER_FLAG_A_BIT]));
   endproperty
   a_r16_flags: assert property (p_r16_flags) else $error("user flags not written"); // R16

   property p_r16_read;
      @(posedge clk) disable iff (rst)
      (!rst && ce && rd && addr == cps_pkg::POWER_CONTROL_ADDR)
         |=> (st_q.rdata[cps_pkg::USER_FLAG_B_BIT] == $past(st_q.userFlagB)
              && st_q.rdata[cps_pkg::USER_FLAG_A_BIT] == $past(st_q.userFlagA));
   endproperty
   a_r16_read: assert property (p_r16_read) else $error("user flags read wrong"); // R16

   property p_r14_set;
      @(posedge clk) disable iff (rst)
      (!rst && ce && wr && addr == cps_pkg::POWER_CONTROL_ADDR && wdata[cps_pkg::POWER_DOWN_REQUEST_BIT])
         |=> st_q.powerDownRequest;
   endproperty
   a_r14_set: assert property (p_r14_set) else $error("power-down request lost"); // R14

   property p_r15_set;
      @(posedge clk) disable iff (rst)
      (!rst && ce && wr && !interruptWake && addr == cps_pkg::POWER_CONTROL_ADDR
       && wdata[cps_pkg::IDLE_REQUEST_BIT]) |=> st_q.idleRequest;
   endproperty
   a_r15_set: assert property (p_r15_set) else $error("idle request lost"); // R15

   property p_r14_reset;
      @(posedge clk) rst |=> (!st_q.powerDownRequest && !st_q.idleRequest);
   endproperty
   a_r14_reset: assert property (p_r14_reset) else $error("reset left a power request"); // R14

   property p_r11_core;
      @(posedge clk) disable iff (rst)
      (!rst && ce && wr && addr == cps_pkg::CORE_CLOCK_SPEED_CONTROL_ADDR)
         |=> (st_q.doubleSpeedReq == $past(wdata[cps_pkg::DOUBLE_SPEED_BIT]));
   endproperty
   a_r11_core: assert property (p_r11_core) else $error("double-speed write lost"); // R11

   property p_r13_write;
      @(posedge clk) disable iff (rst)
      (!rst && ce && wr && addr == cps_pkg::CORE_CLOCK_SPEED_CONTROL_ADDR)
         |=> (st_q.speedSel == $past(wdata[cps_pkg::WATCHDOG_SPEED_SEL_BIT:cps_pkg::TIMER0_SPEED_SEL_BIT]));
   endproperty
   a_r13_write: assert property (p_r13_write) else $error("speed selects not written"); // R13

   property p_r13_spi;
      @(posedge clk) disable iff (rst)
      (!rst && ce && wr && addr == cps_pkg::SPI_CLOCK_SPEED_CONTROL_ADDR)
         |=> (st_q.spiSpeedSel == $past(wdata[cps_pkg::SPI_SPEED_SEL_BIT]));
   endproperty
   a_r13_spi: assert property (p_r13_spi) else $error("spi select not written"); // R13

   property p_r13_half;
      @(posedge clk) disable iff (rst)
      (!rst && ce && st_q.doubleSpeedAct && !st_q.halfPhase)
         |=> ((st_q.ticks.periphTick & $past(periphSel)) == '0);
   endproperty
   a_r13_half: assert property (p_r13_half) else $error("halved peripheral ticked early"); // R13

   property p_r8_phase;
      @(posedge clk) disable iff (rst)
      (st_q.mcPhase <= cps_pkg::MACHINE_CYCLE_LAST);
   endproperty
   a_r8_phase: assert property (p_r8_phase) else $error("machine phase out of range"); // R8

   property p_r15_idle;
      @(posedge clk) disable iff (rst)
      (!rst && ce && st_q.idleRequest) |=> (!st_q.ticks.cpuTick && !st_q.ticks.machineCycleTick);
   endproperty
   a_r15_idle: assert property (p_r15_idle) else $error("core ticked in idle"); // R15

   property p_r9_hold;
      @(posedge clk) disable iff (rst)
      (!rst && ce && st_q.oscHalf) |=> $stable(st_q.doubleSpeedAct);
   endproperty
   a_r9_hold: assert property (p_r9_hold) else $error("mode moved off the halved edge"); // R9

endmodule : cps_clock_prescaler

//--- sim/cps_clock_prescaler_tb.sv
// Purpose: self-checking bench for the clock prescaler and speed select block
// Assumes: clk is the oscillator at 40 MHz, ce held high except for one refused reload write
// Notes: tick periods measured on the falling edge, after registered outputs settle
module cps_clock_prescaler_tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic                             clk, rst, ce, wr, rd;
   logic                             securityDoubleSpeed, interruptWake;
   logic [7:0]                       addr, wdata, rdata, rb, r;
   logic                             cpuClkTick, machineCycleTick;
   logic                             doubleSpeedActive, idleActive, powerDownActive;
   logic [cps_pkg::PERIPH_COUNT-1:0] periphClkTick;
   int                               fails, n_checks, cnt, m, j;

   // Oscillator
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   cps_clock_prescaler DUT (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .securityDoubleSpeed(securityDoubleSpeed), .interruptWake(interruptWake),
      .cpuClkTick(cpuClkTick), .machineCycleTick(machineCycleTick), .periphClkTick(periphClkTick),
      .doubleSpeedActive(doubleSpeedActive), .idleActive(idleActive), .powerDownActive(powerDownActive));

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : report_and_stop

   // One-cycle strobes, launched just after a rising edge
   task automatic busWrite(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : busWrite

   task automatic busRead(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : busRead

   // Index 0..6 peripheral, 7 core, 8 machine cycle
   function automatic logic tickOf(input int sel);
      if (sel < 7) return periphClkTick[sel];
      return (sel == 7) ? cpuClkTick : machineCycleTick;
   endfunction : tickOf

   function automatic int expPer(input logic [7:0] rl, input bit ds);
      int b;
      b = ds ? 1 : 2;
      return (rl == 8'hff) ? b : b * 2 * (255 - int'(rl));
   endfunction : expPer

   task automatic countTicks(input int sel, input int n, output int c);
      c = 0;
      repeat (n) begin
         @(negedge clk);
         if (tickOf(sel) === 1'b1) c++;
      end
   endtask : countTicks

   // First two gaps skipped: a new reload only lands at the period boundary
   task automatic checkPer(input int sel, input int e);
      int i;
      int k;
      for (k = 0; k < 3; k++) begin
         i = 0;
         do begin
            @(negedge clk);
            i++;
         end while (tickOf(sel) !== 1'b1 && i < 8000);
         if (i >= 8000) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, 32'h0, 32'h1);
            report_and_stop();
         end
      end
      check(16'(i), 16'(e));
   endtask : checkPer

   initial begin
      rst = 1'b1; ce = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
      securityDoubleSpeed = 1'b0; interruptWake = 1'b0; fails = 0; n_checks = 0;
      void'($urandom(22));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      // Reset contents and an unmapped place
      busRead(cps_pkg::PRESCALER_RELOAD_ADDR, rb); check(16'(rb), 16'h00ff);
      busRead(cps_pkg::CORE_CLOCK_SPEED_CONTROL_ADDR, rb); check(16'(rb), 16'h0000);
      busRead(cps_pkg::SPI_CLOCK_SPEED_CONTROL_ADDR, rb); check(16'(rb), 16'h0000);
      busRead(cps_pkg::POWER_CONTROL_ADDR, rb); check(16'(rb), 16'h0000);
      busRead(8'h55, rb); check(16'(rb), 16'h0000);
      check(16'(doubleSpeedActive), 16'h0000);
      checkPer(7, 2);
      checkPer(8, 12);
      $display("test reset done");
      // Reload sweep in standard then double speed, corners first
      for (m = 0; m < 2; m++) begin
         busWrite(cps_pkg::CORE_CLOCK_SPEED_CONTROL_ADDR, {7'h00, m[0]});
         repeat (3) @(negedge clk);
         check(16'(doubleSpeedActive), 16'(m[0]));
         for (j = 0; j < 6; j++) begin
            r = (j == 0) ? 8'h00 : (j == 1) ? 8'hff : 8'hff - 8'($urandom % 20 + 1);
            busWrite(cps_pkg::PRESCALER_RELOAD_ADDR, r);
            busRead(cps_pkg::PRESCALER_RELOAD_ADDR, rb); check(16'(rb), 16'(r));
            checkPer(7, expPer(r, m[0]));
            checkPer(3, expPer(r, m[0]));
         end
         checkPer(8, 6 * expPer(r, m[0]));
         $display("test mode %0d done", m);
      end
      // One halved peripheral at a time, double speed, fastest reload
      busWrite(cps_pkg::PRESCALER_RELOAD_ADDR, 8'hff);
      for (j = 0; j < 7; j++) begin
         if (j < 6) busWrite(cps_pkg::CORE_CLOCK_SPEED_CONTROL_ADDR, 8'(8'h02 << j) | 8'h01);
         else begin
            busWrite(cps_pkg::CORE_CLOCK_SPEED_CONTROL_ADDR, 8'h01);
            busWrite(cps_pkg::SPI_CLOCK_SPEED_CONTROL_ADDR, 8'h01);
         end
         checkPer(j, 2);
         checkPer((j + 1) % 7, 1);
         checkPer(7, 1);
      end
      // Selections ignored in standard mode
      busWrite(cps_pkg::CORE_CLOCK_SPEED_CONTROL_ADDR, 8'h7e);
      busRead(cps_pkg::CORE_CLOCK_SPEED_CONTROL_ADDR, rb); check(16'(rb), 16'h007e);
      checkPer(0, 2);
      checkPer(6, 2);
      busWrite(cps_pkg::SPI_CLOCK_SPEED_CONTROL_ADDR, 8'h00);
      $display("test speed select done");
      // Idle with both flags set, then woken by an interrupt
      busWrite(cps_pkg::POWER_CONTROL_ADDR, 8'h0d);
      busRead(cps_pkg::POWER_CONTROL_ADDR, rb); check(16'(rb), 16'h000d);
      check(16'(idleActive), 16'h0001);
      countTicks(7, 40, cnt); check(16'(cnt), 16'h0000);
      checkPer(0, 2);
      @(posedge clk);
      interruptWake <= 1'b1;
      @(posedge clk);
      interruptWake <= 1'b0;
      repeat (2) @(negedge clk);
      check(16'(idleActive), 16'h0000);
      busRead(cps_pkg::POWER_CONTROL_ADDR, rb); check(16'(rb), 16'h000c);
      checkPer(7, 2);
      // Writes refused while the clock enable is low
      ce <= 1'b0;
      busWrite(cps_pkg::PRESCALER_RELOAD_ADDR, 8'h00);
      ce <= 1'b1;
      busRead(cps_pkg::PRESCALER_RELOAD_ADDR, rb); check(16'(rb), 16'h00ff);
      $display("test idle done");
      // Power-down stops everything until a reset, strap now set
      busWrite(cps_pkg::POWER_CONTROL_ADDR, 8'h02);
      repeat (2) @(negedge clk);
      check(16'(powerDownActive), 16'h0001);
      countTicks(7, 40, cnt); check(16'(cnt), 16'h0000);
      countTicks(5, 40, cnt); check(16'(cnt), 16'h0000);
      @(posedge clk);
      rst <= 1'b1;
      securityDoubleSpeed <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(negedge clk);
      check(16'(powerDownActive), 16'h0000);
      check(16'(doubleSpeedActive), 16'h0001);
      busRead(cps_pkg::POWER_CONTROL_ADDR, rb); check(16'(rb), 16'h0000);
      busRead(cps_pkg::CORE_CLOCK_SPEED_CONTROL_ADDR, rb); check(16'(rb), 16'h0001);
      busRead(cps_pkg::PRESCALER_RELOAD_ADDR, rb); check(16'(rb), 16'h00ff);
      checkPer(7, 1);
      checkPer(8, 6);
      $display("test power down done");
      report_and_stop();
   end
endmodule : cps_clock_prescaler_tb
